// ==== core/program_sequencer.sv ====
// program sequencer: phase generator, program counter, fetch/execute overlap and stack control
`timescale 1ns/1ps
`include "seq_regs.svh"

module program_sequencer
  import seq_pkg::*;
#(
  parameter int STACK_DEPTH = `SEQ_STACK_DEPTH
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // register bus
  input  wire logic [`SEQ_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`SEQ_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // program memory
  output pc_t                         fetch_addr,
  output logic                        fetch_en,
  input  wire instr_t                 instr_data,
  // decoder
  output phase_t                      instruction_phases,
  output instr_t                      exec_instr,
  output logic                        exec_valid,
  input  wire exec_ctl_t              exec_ctl,
  // interrupt controller
  input  wire logic                   irq_pending,
  input  wire pc_t                    irq_vector,
  output logic                        irq_ack
);

  seq_state_t s;
  seq_state_t next_s;
  stack_req_t stack_req;
  logic       stack_full;
  pc_t        stack_top;

  // entries and pointer live only inside the stack module
  return_stack #(
    .DEPTH    (STACK_DEPTH)
  ) u_stack (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .req      (stack_req),
    .full     (stack_full),
    .pop_data (stack_top)
  );

  logic                   xfer;
  logic                   wr_fire;
  logic [`SEQ_ADDR_W-1:0] wr_addr;
  logic [31:0]            wr_data;
  logic                   wr_strb0;
  logic [31:0]            status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SEQ_STAT_PHASE_LSB +: 4] = s.ph;
    status_word[`SEQ_STAT_DUMMY_BIT]      = ~s.ir_valid;
    status_word[`SEQ_STAT_PEND_BIT]       = s.pcl_pend;
  end

  always_comb begin
    next_s    = s;
    stack_req = '0;
    xfer      = 1'b0;
    wr_fire   = 1'b0;
    wr_addr   = s.aw_addr;
    wr_data   = s.wdata;
    wr_strb0  = s.wstrb0;
    next_s.fetch_en = 1'b0;
    next_s.irq_ack  = 1'b0;

    // phase rotation
    case (s.ph)
      PH_T1: begin
        next_s.ph = PH_T2;
      end
      PH_T2: begin
        next_s.ph = PH_T3;
      end
      PH_T3: begin
        next_s.ph = PH_T4;
      end
      PH_T4: begin
        next_s.ph = PH_T1;
      end
      default: begin
        next_s.ph = PH_T1;
      end
    endcase

    // entering the first phase: advance the counter, start the next fetch
    if (s.ph == PH_T4) begin
      next_s.ir       = instr_data;
      next_s.ir_valid = 1'b1;
      if (s.ir_valid) begin
        if (exec_ctl.subroutine_return || exec_ctl.interrupt_return) begin
          next_s.pc     = stack_top;
          stack_req.pop = 1'b1;
          xfer          = 1'b1;
        end else if (exec_ctl.call) begin
          stack_req.push = 1'b1;
          stack_req.data = s.fetch_addr;
          next_s.pc      = exec_ctl.target;
          xfer           = 1'b1;
        end else if (exec_ctl.branch_instr) begin
          next_s.pc = exec_ctl.target;
          xfer      = 1'b1;
        end else if (exec_ctl.skip_taken) begin
          xfer = 1'b1;
        end
      end
      // right after reset nothing has been fetched yet, so this cycle runs as a dummy
      if (s.pc == s.fetch_addr) begin
        xfer = 1'b1;
      end
      if (!xfer && s.pcl_pend) begin
        next_s.pc       = {s.pc[`SEQ_PC_W-1:`SEQ_PCL_W], s.pcl_val};
        next_s.pcl_pend = 1'b0;
        xfer            = 1'b1;
      end
      if (!xfer && s.ir_valid && irq_pending && !stack_full) begin
        stack_req.push = 1'b1;
        stack_req.data = s.fetch_addr;
        next_s.pc      = irq_vector;
        next_s.irq_ack = 1'b1;
        xfer           = 1'b1;
      end
      if (xfer) begin
        next_s.ir_valid = 1'b0;
      end
    end

    if (s.ph == PH_T4) begin
      next_s.fetch_addr = next_s.pc;
      next_s.fetch_en   = 1'b1;
      next_s.pc         = next_s.pc + pc_t'(1);
    end

    // write channel: address and data in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
      wr_addr        = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb0 = s_axi_wstrb[0];
      wr_data       = s_axi_wdata;
      wr_strb0      = s_axi_wstrb[0];
    end
    if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
      wr_fire       = 1'b1;
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `SEQ_RESP_OKAY;
      if (wr_addr == `SEQ_OFF_PC_LOW) begin
        if (wr_strb0) begin
          // a new write wins over the clear at the phase boundary
          next_s.pcl_pend = 1'b1;
          next_s.pcl_val  = wr_data[`SEQ_PCL_W-1:0];
        end
      end else if (wr_addr != `SEQ_OFF_STATUS) begin
        next_s.bresp = `SEQ_RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // read channel
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `SEQ_RESP_OKAY;
      if (s_axi_araddr == `SEQ_OFF_PC_LOW) begin
        next_s.rdata = {24'h00_0000, s.pc[`SEQ_PCL_W-1:0]};
      end else if (s_axi_araddr == `SEQ_OFF_STATUS) begin
        next_s.rdata = status_word;
      end else begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = `SEQ_RESP_SLVERR;
      end
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s            <= '0;
      s.ph         <= PH_T4;
      s.pc         <= `SEQ_PC_RESET;
      s.fetch_addr <= `SEQ_PC_RESET;
      s.awready    <= 1'b1;
      s.wready     <= 1'b1;
      s.arready    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    s_axi_awready      = s.awready;
    s_axi_wready       = s.wready;
    s_axi_bresp        = s.bresp;
    s_axi_bvalid       = s.bvalid;
    s_axi_arready      = s.arready;
    s_axi_rdata        = s.rdata;
    s_axi_rresp        = s.rresp;
    s_axi_rvalid       = s.rvalid;
    fetch_addr         = s.fetch_addr;
    fetch_en           = s.fetch_en;
    instruction_phases = s.ph;
    exec_instr         = s.ir;
    exec_valid         = s.ir_valid;
    irq_ack            = s.irq_ack;
  end

endmodule

// ==== core/return_stack.sv ====
// hardware return-address stack, circular so that an overflow drops the oldest entry
`timescale 1ns/1ps
`include "seq_regs.svh"

module return_stack
  import seq_pkg::*;
#(
  parameter int DEPTH = `SEQ_STACK_DEPTH
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire stack_req_t req,
  output logic            full,
  output pc_t             pop_data
);

  stack_state_t s;
  stack_state_t next_s;

  localparam logic [3:0] LAST  = 4'(DEPTH - 1);
  localparam logic [3:0] LIMIT = 4'(DEPTH);

  logic [3:0] below_top;

  always_comb begin
    below_top = (s.top == 4'h0) ? LAST : s.top - 4'h1;
    full      = (s.count == LIMIT);
    pop_data  = s.entry[below_top];
  end

  always_comb begin
    next_s = s;
    if (req.push) begin
      // writes over the oldest entry once full
      for (int i = 0; i < DEPTH; i++) begin
        if (s.top == 4'(i)) begin
          next_s.entry[i] = req.data;
        end
      end
      next_s.top = (s.top == LAST) ? 4'h0 : s.top + 4'h1;
      if (!full) begin
        next_s.count = s.count + 4'h1;
      end
    end else if (req.pop) begin
      next_s.top = below_top;
      if (s.count != 4'h0) begin
        next_s.count = s.count - 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// ==== dv/program_memory_model.sv ====
// program memory model: word holds its own address
`timescale 1ns/1ps
module program_memory_model
  import seq_pkg::*;
(
  input  wire logic aclk,
  input  wire pc_t  fetch_addr,
  input  wire logic fetch_en,
  output instr_t    instr_data
);
  pc_t held;
  always_ff @(posedge aclk) begin
    if (fetch_en) begin
      held <= fetch_addr;
    end
  end
  assign instr_data = {2'h3, held};
endmodule

// ==== dv/program_sequencer_bench.sv ====
// self-checking bench of the program sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("mismatch %0t %h %h", $time, a, b); end end
module program_sequencer_bench
  import seq_pkg::*;
;
  logic        aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  pc_t         fetch_addr, irq_vector, pcx;
  logic        fetch_en, exec_valid, irq_pending, irq_ack;
  instr_t      instr_data, exec_instr;
  phase_t      instruction_phases;
  exec_ctl_t   exec_ctl;
  int          fails, samples_checked, cyc;
  program_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_addr,
    .fetch_en, .instr_data, .instruction_phases, .exec_instr, .exec_valid, .exec_ctl, .irq_pending,
    .irq_vector, .irq_ack);
  program_memory_model mem (.aclk, .fetch_addr, .fetch_en, .instr_data);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic finish_test;
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, r)
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // decoder answer at the end of a real cycle; returns in the next first phase
  task automatic ctl(input exec_ctl_t c);
    do @(posedge aclk); while (!(instruction_phases == PH_T3 && exec_valid === 1'b1));
    exec_ctl <= c;
    @(posedge aclk);
    exec_ctl <= '0;
    @(posedge aclk);
  endtask
  task automatic xfer(input logic is_call, input pc_t t);
    exec_ctl_t c;
    c = '0;
    c.call = is_call;
    c.branch_instr = !is_call;
    c.target = t;
    ctl(c);
    `CHK(fetch_addr, t)
    `CHK(exec_valid, 1'b0)
    pcx = pc_t'(t + 1);
  endtask
  task automatic ret(input logic iform, input pc_t v);
    exec_ctl_t c;
    c = '0;
    c.subroutine_return = !iform;
    c.interrupt_return = iform;
    ctl(c);
    `CHK(fetch_addr, v)
  endtask
  task automatic t_stack;
    pc_t q[$];
    pc_t v;
    int  i;
    xfer(1'b0, 14'h0100);
    for (i = 0; i < 12; i++) begin
      q.push_back(pcx);
      xfer(1'b1, pc_t'(14'h0200 + i * 16));
    end
    irq_pending <= 1'b1;
    repeat (12) begin
      @(posedge aclk);
      `CHK(irq_ack, 1'b0)
    end
    v = q.pop_back();
    ret(1'b0, v);
    for (i = 0; i < 16 && irq_ack !== 1'b1; i++) @(posedge aclk);
    `CHK(irq_ack, 1'b1)
    `CHK(fetch_addr, irq_vector)
    irq_pending <= 1'b0;
    q.push_back(pc_t'(v + 1));
    pcx = pc_t'(irq_vector + 1);
    q.push_back(pcx);
    void'(q.pop_front());
    xfer(1'b1, 14'h3f00);
    for (i = 0; i < 12; i++) ret(i == 0, q.pop_back());
  endtask
  task automatic t_flow;
    exec_ctl_t c;
    xfer(1'b0, 14'h2aa5);
    repeat (4) @(posedge aclk);
    `CHK(exec_instr, {2'h3, 14'h2aa5})
    c = '0;
    c.skip_taken = 1'b1;
    ctl(c);
    `CHK(exec_valid, 1'b0)
    repeat (4) @(posedge aclk);
    `CHK({exec_valid, exec_instr}, {1'b1, 2'h3, 14'h2aa7})
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    wr(12'h000, 32'h0000005a, 2'h0);
    for (i = 0; i < 16 && !(instruction_phases == PH_T1 && exec_valid === 1'b0); i++) @(posedge aclk);
    `CHK(fetch_addr, 14'h2a5a)
    repeat (4) @(posedge aclk);
    `CHK(exec_instr, {2'h3, 14'h2a5a})
    rd(12'h000, d, r);
    `CHK({r, d}, {2'h0, 24'h0, 8'h5c})
    rd(12'h008, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    wr(12'h008, 32'h1, 2'h2);
    wr(12'h004, 32'h1, 2'h0);
    rd(12'h004, d, r);
    `CHK({r, d[31:6], d[5]}, 29'h0)
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, irq_pending} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    exec_ctl = '0;
    irq_vector = 14'h0040;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(instruction_phases, PH_T4)
    @(posedge aclk);
    `CHK({fetch_en, exec_valid, fetch_addr}, {2'b10, 14'h0})
    t_stack;
    t_flow;
    t_regs;
    finish_test;
  end
endmodule

// ==== dv/program_sequencer_properties.sv ====
// port assertions of the program sequencer
`timescale 1ns/1ps
module program_sequencer_properties
  import seq_pkg::*;
#(
  parameter int STACK_DEPTH = 12
) (
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      s_axi_arvalid,
  input wire logic      s_axi_arready,
  input wire logic      s_axi_rvalid,
  input wire pc_t       fetch_addr,
  input wire logic      fetch_en,
  input wire phase_t    instruction_phases,
  input wire logic      exec_valid,
  input wire exec_ctl_t exec_ctl,
  input wire pc_t       irq_vector,
  input wire logic      irq_ack
);
  // reset seen one edge late, so attempts on the release edge are skipped
  logic past_aresetn;
  always_ff @(posedge aclk) begin
    past_aresetn <= aresetn;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !past_aresetn);
  wire t1  = instruction_phases == PH_T1;
  wire t4v = instruction_phases == PH_T4 && exec_valid;
  wire ret = exec_ctl.subroutine_return || exec_ctl.interrupt_return;
  sequence s_dummy;
    fetch_en && !exec_valid;
  endsequence
  sequence s_target;
    s_dummy ##0 fetch_addr == $past(exec_ctl.target);
  endsequence
  AST_PHASE_STEP:
    assert property (instruction_phases != PH_T4 |=> instruction_phases == $past(instruction_phases) << 1)
    else $error("phase did not step");
  AST_PHASE_WRAP:
    assert property (instruction_phases == PH_T4 |=> instruction_phases == PH_T1)
    else $error("phase did not wrap");
  AST_FETCH_T1:
    assert property (fetch_en |-> t1 ##1 (!fetch_en && $stable(fetch_addr)) [*3] ##1 fetch_en)
    else $error("fetch not once per cycle");
  AST_PC_INC:
    assert property (t1 && exec_valid |-> fetch_addr == pc_t'($past(fetch_addr, 4) + 1))
    else $error("counter not incremented");
  AST_BRANCH:
    assert property (t4v && exec_ctl.branch_instr && !exec_ctl.call && !ret |=> s_target)
    else $error("branch target wrong");
  AST_CALL:
    assert property (t4v && exec_ctl.call && !ret |=> s_target)
    else $error("call target wrong");
  AST_SKIP:
    assert property (t4v && exec_ctl.skip_taken && !exec_ctl.branch_instr && !exec_ctl.call && !ret |=> !exec_valid [*4])
    else $error("skip gave no dummy");
  AST_IRQ:
    assert property (irq_ack |-> t1 && !exec_valid && fetch_addr == irq_vector)
    else $error("interrupt entry wrong");
  AST_RESET:
    assert property ($rose(aresetn) |-> instruction_phases == PH_T4 ##1 s_dummy ##0 fetch_addr == 0)
    else $error("reset start wrong");
  AST_READ:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule
bind program_sequencer program_sequencer_properties #(.STACK_DEPTH(STACK_DEPTH)) props (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .fetch_addr, .fetch_en, .instruction_phases, .exec_valid,
  .exec_ctl, .irq_vector, .irq_ack);

// ==== inc/seq_pkg.sv ====
// types shared by the program sequencer and its return-address stack
`include "seq_regs.svh"

package seq_pkg;

  typedef logic [`SEQ_PC_W-1:0]    pc_t;
  typedef logic [`SEQ_INSTR_W-1:0] instr_t;

  typedef enum logic [3:0] {
    PH_T1 = 4'b0001,
    PH_T2 = 4'b0010,
    PH_T3 = 4'b0100,
    PH_T4 = 4'b1000
  } phase_t;

  // decision of the decoder for the instruction in execution, sampled at the end of the last phase
  typedef struct packed {
    logic branch_instr;
    logic call;
    logic subroutine_return;
    logic interrupt_return;
    logic skip_taken;
    pc_t  target;
  } exec_ctl_t;

  typedef struct packed {
    logic push;
    logic pop;
    pc_t  data;
  } stack_req_t;

  typedef struct packed {
    logic [3:0] top;
    logic [3:0] count;
    logic [`SEQ_STACK_DEPTH-1:0][`SEQ_PC_W-1:0] entry;
  } stack_state_t;

  typedef struct packed {
    phase_t                  ph;
    pc_t                     pc;
    pc_t                     fetch_addr;
    logic                    fetch_en;
    instr_t                  ir;
    logic                    ir_valid;
    logic                    pcl_pend;
    logic [`SEQ_PCL_W-1:0]   pcl_val;
    logic                    irq_ack;
    logic                    awready;
    logic                    wready;
    logic                    aw_got;
    logic [`SEQ_ADDR_W-1:0]  aw_addr;
    logic                    w_got;
    logic [31:0]             wdata;
    logic                    wstrb0;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } seq_state_t;

endpackage

// ==== inc/seq_regs.svh ====
// register offsets, field positions, reset values and sizes of the program sequencer
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

`define SEQ_PC_W          14
`define SEQ_STACK_DEPTH   12
`define SEQ_INSTR_W       16
`define SEQ_ADDR_W        12

`define SEQ_OFF_PC_LOW    12'h000
`define SEQ_OFF_STATUS    12'h004

`define SEQ_PC_RESET      14'h0000
`define SEQ_PCL_W         8

`define SEQ_STAT_PHASE_LSB 0
`define SEQ_STAT_DUMMY_BIT 4
`define SEQ_STAT_PEND_BIT  5

`define SEQ_PHASES_PER_CYCLE 4

`define SEQ_RESP_OKAY     2'h0
`define SEQ_RESP_SLVERR   2'h2

`endif
